/* File: hw/led_defines.svh */
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

// register byte offsets
`define LED_OFF_CTRL      4'h0
`define LED_OFF_COLOUR    4'h4
`define LED_OFF_STATUS    4'h8

// control word fields
`define LED_INV_LSB       0
`define LED_MASK_LSB      8
`define LED_LATCH_BIT     16
`define LED_ACKSEL_LSB    20

// colour word fields
`define LED_ACT_LSB       0
`define LED_INACT_LSB     4

// reset values: input 0 assigned, active red, inactive off
`define LED_CTRL_RST      32'h0000_0100
`define LED_COLOUR_RST    32'h0000_0002

// axi responses
`define LED_RESP_OKAY     2'h0
`define LED_RESP_SLVERR   2'h2

// blink timing
`define LED_CLK_MHZ       200
`define LED_BLINK_HALF_MS 250
`define LED_BLINK_HALF_CYC (`LED_BLINK_HALF_MS * 1000 * `LED_CLK_MHZ)

`endif

/* File: hw/led_pkg.sv */
package led_pkg;

  typedef enum logic [2:0] {
    COL_OFF,
    COL_GREEN,
    COL_RED,
    COL_RED_FLASH,
    COL_GREEN_FLASH
  } colour_t;

  typedef struct packed {
    logic green;
    logic red;
  } led_pair_t;

  typedef struct packed {
    logic [4:0] inv;
    logic [4:0] mask;
    logic       latch_en;
    logic [1:0] ack_sel;
    colour_t    act;
    colour_t    inact;
  } cfg_t;

endpackage : led_pkg

/* File: hw/blink_divider.sv */
`timescale 1ns/1ps
module blink_divider #(
  parameter int unsigned HALF = 50000000
) (
  input  wire logic clock,
  input  wire logic rstn,
  output logic      blink_q
);
  localparam int unsigned W = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [W-1:0] LAST = W'(HALF - 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q   <= '0;
      blink_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q   <= '0;
      blink_q <= ~blink_q;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_blink_rate;
    (cnt_q == LAST) |=> (blink_q != $past(blink_q));
  endproperty
  a_blink_rate: assert property (p_blink_rate) else $error("blink did not toggle at wrap");

  property p_blink_hold;
    (cnt_q != LAST) |=> $stable(blink_q);
  endproperty
  a_blink_hold: assert property (p_blink_hold) else $error("blink toggled early");

endmodule : blink_divider

/* File: hw/led_indicator_logic.sv */
// Notes on behaviour
// - each input has its own inversion, default off
// - combined true shows the active colour
// - combined false shows inactive colour, default off
// - latch option holds the active state after pickup
// - ack clears hold only once inputs gone
// - ack has effect only with latching enabled
`timescale 1ns/1ps
`include "led_defines.svh"
module led_indicator_logic #(
  parameter int unsigned BLINK_HALF_CYCLES = `LED_BLINK_HALF_CYC,
  parameter int unsigned ADDR_W            = 4
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [4:0]        status_in,
  input  wire logic [3:0]        ack_in,
  output led_pkg::led_pair_t     led_q,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  import led_pkg::*;

  localparam logic [ADDR_W-1:0] A_CTRL   = ADDR_W'(`LED_OFF_CTRL);
  localparam logic [ADDR_W-1:0] A_COLOUR = ADDR_W'(`LED_OFF_COLOUR);
  localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(`LED_OFF_STATUS);

  function automatic cfg_t to_cfg(logic [31:0] ctrl, logic [31:0] col);
    cfg_t c;
    c.inv      = ctrl[`LED_INV_LSB +: 5];
    c.mask     = ctrl[`LED_MASK_LSB +: 5];
    c.latch_en = ctrl[`LED_LATCH_BIT];
    c.ack_sel  = ctrl[`LED_ACKSEL_LSB +: 2];
    c.act      = colour_t'(col[`LED_ACT_LSB +: 3]);
    c.inact    = colour_t'(col[`LED_INACT_LSB +: 3]);
    return c;
  endfunction : to_cfg

  function automatic logic [31:0] ctrl_word(cfg_t c);
    logic [31:0] w;
    w = '0;
    w[`LED_INV_LSB +: 5]    = c.inv;
    w[`LED_MASK_LSB +: 5]   = c.mask;
    w[`LED_LATCH_BIT]       = c.latch_en;
    w[`LED_ACKSEL_LSB +: 2] = c.ack_sel;
    return w;
  endfunction : ctrl_word

  function automatic logic [31:0] colour_word(cfg_t c);
    logic [31:0] w;
    w = '0;
    w[`LED_ACT_LSB +: 3]   = c.act;
    w[`LED_INACT_LSB +: 3] = c.inact;
    return w;
  endfunction : colour_word

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic is_mapped(logic [ADDR_W-1:0] a);
    return (a == A_CTRL) || (a == A_COLOUR) || (a == A_STATUS);
  endfunction : is_mapped

  // codes 5..7 fall to dark rather than a guessed colour
  function automatic led_pair_t drive(colour_t c, logic blink);
    led_pair_t p;
    p = '0;
    case (c)
      COL_GREEN:       p.green = 1'b1;
      COL_RED:         p.red   = 1'b1;
      COL_RED_FLASH:   p.red   = blink;
      COL_GREEN_FLASH: p.green = blink;
      default:         p       = '0;
    endcase
    return p;
  endfunction : drive

  localparam cfg_t CFG_RST = to_cfg(`LED_CTRL_RST, `LED_COLOUR_RST);

  cfg_t              cfg_q;
  logic              held_q;
  logic              blink;
  logic [4:0]        shaped;
  logic              combined;
  logic              ack;
  logic              active;
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;
  logic [31:0]       status_word;

  blink_divider #(
    .HALF (BLINK_HALF_CYCLES)
  ) u_blink (
    .clock   (clock),
    .rstn    (rstn),
    .blink_q (blink)
  );

  assign shaped   = (status_in ^ cfg_q.inv) & cfg_q.mask;
  assign combined = |shaped;
  assign ack      = cfg_q.latch_en & ack_in[cfg_q.ack_sel];
  assign active   = combined | (held_q & cfg_q.latch_en);
  assign do_write = aw_full_q & w_full_q & ~bvalid;

  assign status_word = {21'h0, shaped, 1'b0, led_q, active, held_q, combined};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      held_q <= 1'b0;
    end else if (!cfg_q.latch_en) begin
      held_q <= 1'b0;
    end else if (combined) begin
      held_q <= 1'b1;
    end else if (ack) begin
      held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      led_q <= '0;
    end else if (active) begin
      led_q <= drive(cfg_q.act, blink);
    end else begin
      led_q <= drive(cfg_q.inact, blink);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
    end else if (do_write && waddr_q == A_CTRL) begin
      cfg_q <= to_cfg(merge(ctrl_word(cfg_q), wdata_q, wstrb_q), colour_word(cfg_q));
    end else if (do_write && waddr_q == A_COLOUR) begin
      cfg_q <= to_cfg(ctrl_word(cfg_q), merge(colour_word(cfg_q), wdata_q, wstrb_q));
    end
  end

  // address and data are taken in either order, then held until the response
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awready   <= 1'b1;
      aw_full_q <= 1'b0;
      waddr_q   <= '0;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      aw_full_q <= 1'b1;
      waddr_q   <= awaddr;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wready   <= 1'b1;
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wvalid && wready) begin
      wready   <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= `LED_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(waddr_q) ? `LED_RESP_OKAY : `LED_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `LED_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= is_mapped(araddr) ? `LED_RESP_OKAY : `LED_RESP_SLVERR;
      case (araddr)
        A_CTRL:   rdata <= ctrl_word(cfg_q);
        A_COLOUR: rdata <= colour_word(cfg_q);
        A_STATUS: rdata <= status_word;
        default:  rdata <= '0;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_invert;
    (cfg_q.mask == 5'h1F) |-> (combined == (status_in != cfg_q.inv));
  endproperty
  a_invert: assert property (p_invert) else $error("inverted inputs not cancelled");

  property p_active_green;
    (active && cfg_q.act == COL_GREEN) |=> (led_q.green && !led_q.red);
  endproperty
  a_active_green: assert property (p_active_green) else $error("active green wrong");

  property p_inactive_off;
    (!active && cfg_q.inact == COL_OFF) |=> (led_q == '0);
  endproperty
  a_inactive_off: assert property (p_inactive_off) else $error("inactive off lit");

  property p_hold;
    (cfg_q.latch_en && combined) ##1 (cfg_q.latch_en && !combined && !ack) |-> active;
  endproperty
  a_hold: assert property (p_hold) else $error("latched state lost");

  property p_ack_ignored;
    (held_q && cfg_q.latch_en && ack && combined) |=> held_q;
  endproperty
  a_ack_ignored: assert property (p_ack_ignored) else $error("ack cleared live pickup");

  property p_ack_clear;
    (held_q && cfg_q.latch_en && ack && !combined) |=> !held_q;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear hold");

  property p_no_latch;
    !cfg_q.latch_en |=> !held_q;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("hold without latch option");

  property p_flash;
    (active && cfg_q.act == COL_RED_FLASH) |=> (led_q.red == $past(blink) && !led_q.green);
  endproperty
  a_flash: assert property (p_flash) else $error("red flash not following blink");

  c_latched: cover property (held_q && !combined);
  c_ack_clear: cover property (held_q && ack && !combined ##1 !held_q);
  c_ack_ignored: cover property (held_q && ack && combined);
  c_flash: cover property (active && cfg_q.act == COL_RED_FLASH && $rose(blink));

endmodule : led_indicator_logic

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import led_pkg::*;
  localparam int unsigned HALF  = 4;
  localparam int          LIMIT = 20000;
  logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready, comb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [4:0]  status_in;
  logic [3:0]  ack_in, awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd_d, ctrl;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  a, i;
  logic [15:0] seed;
  led_pair_t   led_q;
  int          n_errors, samples_checked, cyc;

  led_indicator_logic #(.BLINK_HALF_CYCLES(HALF), .ADDR_W(4)) dut (
    .clock(clock), .rstn(rstn), .status_in(status_in), .ack_in(ack_in), .led_q(led_q),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // steady colours only, flashing has its own scenario
  function automatic logic [2:0] pick(input logic [1:0] v);
    pick = (v == 2'h3) ? 3'h0 : {1'b0, v};
  endfunction : pick

  function automatic logic [1:0] col_led(input logic [2:0] c);
    col_led = (c == 3'h1) ? 2'h2 : (c == 3'h2) ? 2'h1 : 2'h0;
  endfunction : col_led

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      r = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // inputs settle, then one edge for any hold to clear and one for the led
  task automatic step(input logic [4:0] st, input logic [3:0] ack, input logic [1:0] exp);
    @(posedge clock);
    status_in <= st;
    ack_in    <= ack;
    repeat (3) @(posedge clock);
    chk(led_q, exp);
  endtask : step

  task automatic flash_chk(input logic [1:0] on);
    int n_on, n_off, n_bad;
    n_on  = 0;
    n_off = 0;
    n_bad = 0;
    repeat (16) begin
      @(posedge clock);
      if (led_q === on) n_on++;
      else if (led_q === 2'h0) n_off++;
      else n_bad++;
    end
    chk({n_bad == 0, n_on > 0, n_off > 0}, 32'h7);
  endtask : flash_chk

  task automatic test_done;
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      test_done;
    end
  end

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {status_in, ack_in, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    seed  = 16'h0017;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h0, rd_d, resp);
    chk(rd_d, 32'h0000_0100);
    rd(4'h4, rd_d, resp);
    chk(rd_d, 32'h0000_0002);
    chk(led_q, 2'h0);
    rd(4'hC, rd_d, resp);
    chk(resp, 2'h2);
    chk(rd_d, 32'h0);
    wr(4'hC, 32'hFFFF_FFFF, resp);
    chk(resp, 2'h2);
    // all inputs assigned, only input 0 inverted, all low
    wr(4'h0, 32'h0000_1F01, resp);
    wr(4'h4, 32'h0000_0021, resp);
    step(5'h00, 4'h0, 2'h2);
    step(5'h01, 4'h0, 2'h1);
    repeat (30) begin
      seed = lfsr(seed);
      ctrl = {10'h0, seed[15:14], 3'h0, 1'b0, 3'h0, seed[12:8], 3'h0, seed[4:0]};
      wr(4'h0, ctrl, resp);
      seed = lfsr(seed);
      a = pick(seed[1:0]);
      i = pick(seed[3:2]);
      wr(4'h4, {25'h0, i, 1'b0, a}, resp);
      seed = lfsr(seed);
      comb = |((seed[4:0] ^ ctrl[4:0]) & ctrl[12:8]);
      step(seed[4:0], seed[8:5], col_led(comb ? a : i));
      rd(4'h8, rd_d, resp);
      chk(rd_d[0], comb);
    end
    wr(4'h0, 32'h0000_0100, resp);
    for (int c = 3; c <= 4; c++) begin
      wr(4'h4, 32'(c), resp);
      status_in <= 5'h01;
      ack_in    <= 4'h0;
      rd(4'h8, rd_d, resp);
      chk(rd_d[2:0], 3'h5);
      flash_chk(c == 3 ? 2'h1 : 2'h2);
    end
    // inputs low first, else enabling the latch picks up at once
    status_in <= 5'h00;
    // latch on, ack line 2, active red, inactive green
    wr(4'h0, 32'h0021_0100, resp);
    wr(4'h4, 32'h0000_0012, resp);
    step(5'h00, 4'h0, 2'h2);
    step(5'h01, 4'h0, 2'h1);
    step(5'h00, 4'h0, 2'h1);
    step(5'h01, 4'h4, 2'h1);
    step(5'h00, 4'h2, 2'h1);
    step(5'h00, 4'h4, 2'h2);
    step(5'h01, 4'h0, 2'h1);
    wr(4'h0, 32'h0020_0100, resp);
    step(5'h00, 4'h0, 2'h2);
    step(5'h01, 4'hF, 2'h1);
    step(5'h00, 4'h0, 2'h2);
    // unused colour code 5 stays dark but reads back as written
    wr(4'h4, 32'h0000_0015, resp);
    step(5'h01, 4'h0, 2'h0);
    rd(4'h4, rd_d, resp);
    chk(rd_d, 32'h0000_0015);
    test_done;
  end
endmodule : tb
